/* File: hw/afc_async_flash_ctrl.sv */
`timescale 1ns/1ps
// Functional notes
// - Wait select-low to data-valid before read capture.
// - Wait address-valid to data-valid before read capture.
// - Page-mode flash uses page access time on hits.
// - Let bus float after select rises.
// - Let bus float after output enable rises.
// - Hold select low for write cycle time.
// - Hold write strobe low for pulse width.
// - Idle cycles between writes from phase time.
// - Zero phase still gives one select-high cycle.
// - Write-high to bus-drive gap before reads.
// - Flash/PSRAM recovery idle after burst last.
// - Counters calibrated from bus clock period.
// - Forwarded clock always driven, float held low.
// - User can drive or float config pins.
// - Low data bits readable through sense port.
// - Bypass pins delayed to align with primitive path.
module afc_async_flash_ctrl (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire afc_pkg::afc_mem_type_t i_mem_type,
   input wire logic i_cfg_pins_float,
   input wire logic i_cmd_valid,
   output logic o_cmd_ready,
   input wire logic i_cmd_write,
   input wire logic i_cmd_last,
   input wire logic [afc_pkg::ADDR_W-1:0] i_cmd_addr,
   input wire logic [afc_pkg::DATA_W-1:0] i_cmd_wdata,
   output logic o_rd_valid,
   output logic [afc_pkg::DATA_W-1:0] o_rd_data,
   output logic o_wr_done,
   output logic o_busy,
   output logic o_user_clock_out_port,
   output logic o_user_clock_float_port,
   output logic o_flash_select_out_port_n,
   output logic o_flash_select_float_port,
   output logic [afc_pkg::CFG_DQ_W-1:0] o_cfg_dq_out,
   output logic [afc_pkg::CFG_DQ_W-1:0] o_pin_float_port,
   input wire logic [afc_pkg::CFG_DQ_W-1:0] i_pin_sense_port,
   output logic [afc_pkg::DATA_W-afc_pkg::CFG_DQ_W-1:0] o_dq_hi_out,
   output logic o_dq_hi_oe,
   input wire logic [afc_pkg::DATA_W-afc_pkg::CFG_DQ_W-1:0] i_dq_hi_in,
   output logic [afc_pkg::ADDR_W-1:0] o_mem_addr,
   output logic o_mem_output_low,
   output logic o_mem_write_low
);

   localparam int unsigned HI_W = afc_pkg::DATA_W - afc_pkg::CFG_DQ_W;
   localparam int unsigned CW = afc_pkg::CNT_W;

   // Read waits include the synchroniser and the bypass alignment stage
   localparam logic [CW-1:0] RD_WAIT = CW'(afc_pkg::max2(afc_pkg::SELECT_TO_VALID_CYC,
      afc_pkg::ADDR_TO_VALID_CYC) + afc_pkg::SYNC_STAGES + afc_pkg::ALIGN_STAGES);
   localparam logic [CW-1:0] PAGE_WAIT = CW'(afc_pkg::PAGE_ACCESS_CYC + afc_pkg::SYNC_STAGES
      + afc_pkg::ALIGN_STAGES);
   localparam logic [CW-1:0] FLOAT_GAP = CW'(afc_pkg::max2(afc_pkg::SELECT_HIGH_FLOAT_CYC,
      afc_pkg::OUTPUT_HIGH_FLOAT_CYC) + afc_pkg::ALIGN_STAGES);
   localparam logic [CW-1:0] WR_PULSE = CW'(afc_pkg::WRITE_PULSE_CYC);
   localparam logic [CW-1:0] WR_CYCLE = CW'(afc_pkg::max2(afc_pkg::WRITE_CYCLE_CYC,
      afc_pkg::WRITE_PULSE_CYC));
   localparam logic [CW-1:0] WR_PHASE = CW'(afc_pkg::max2(afc_pkg::WRITE_PHASE_CYC, 1));
   localparam logic [CW-1:0] WR_RECOVER = CW'(afc_pkg::max2(afc_pkg::WRITE_RECOVERY_CYC, 1));
   localparam logic [CW-1:0] WR_TO_READ = CW'(afc_pkg::WRITE_HIGH_DRIVE_CYC);

   typedef struct packed {
      afc_pkg::afc_state_t state;
      logic [CW-1:0] cnt;
      logic [CW-1:0] gap;
      logic [CW-1:0] rd_gap;
      logic last;
      logic page_open;
      logic [afc_pkg::ADDR_W-1:0] page_addr;
      logic clk_div;
      logic cs_low;
      logic oe_low;
      logic we_low;
      logic dq_oe;
      logic [afc_pkg::DATA_W-1:0] dq_out;
      logic [afc_pkg::ADDR_W-1:0] addr;
      logic al_oe_low;
      logic al_we_low;
      logic al_dq_oe;
      logic [HI_W-1:0] al_dq_hi;
      logic [afc_pkg::ADDR_W-1:0] al_addr;
      logic [afc_pkg::DATA_W-1:0] s1;
      logic [afc_pkg::DATA_W-1:0] s2;
      logic rd_valid;
      logic [afc_pkg::DATA_W-1:0] rd_data;
      logic wr_done;
   } afc_regs_t;

   afc_regs_t q;
   afc_regs_t d;
   logic cmd_take;
   logic page_hit;
   logic flash_like;

   always_comb begin
      o_cmd_ready = (q.state == afc_pkg::AFC_ST_IDLE) && (q.gap == '0)
         && (i_cmd_write || (q.rd_gap == '0));
   end

   assign cmd_take = i_cmd_valid && o_cmd_ready;
   assign page_hit = (i_mem_type == afc_pkg::AFC_MEM_PAGE_FLASH) && q.page_open
      && (i_cmd_addr[afc_pkg::ADDR_W-1:afc_pkg::PAGE_BITS]
      == q.page_addr[afc_pkg::ADDR_W-1:afc_pkg::PAGE_BITS]);
   assign flash_like = (i_mem_type != afc_pkg::AFC_MEM_SRAM);

   always_comb begin
      d = q;
      d.rd_valid = 1'b0;
      d.wr_done = 1'b0;
      d.clk_div = ~q.clk_div;
      // Both data paths share the same two-stage synchroniser
      d.s1 = {i_dq_hi_in, i_pin_sense_port};
      d.s2 = q.s1;
      // Bypass pins trail one stage to match the primitive's longer path
      d.al_oe_low = q.oe_low;
      d.al_we_low = q.we_low;
      d.al_dq_oe = q.dq_oe;
      d.al_dq_hi = q.dq_out[afc_pkg::DATA_W-1:afc_pkg::CFG_DQ_W];
      d.al_addr = q.addr;
      if (q.gap != '0) begin
         d.gap = q.gap - CW'(1);
      end
      if (q.rd_gap != '0) begin
         d.rd_gap = q.rd_gap - CW'(1);
      end
      unique case (q.state)
         afc_pkg::AFC_ST_IDLE: begin
            if (cmd_take) begin
               d.addr = i_cmd_addr;
               d.cs_low = 1'b1;
               if (i_cmd_write) begin
                  d.state = afc_pkg::AFC_ST_WRITE;
                  d.cnt = '0;
                  d.we_low = 1'b1;
                  d.dq_oe = 1'b1;
                  d.dq_out = i_cmd_wdata;
                  d.last = i_cmd_last;
                  d.page_open = 1'b0;
               end else begin
                  d.state = afc_pkg::AFC_ST_READ;
                  d.oe_low = 1'b1;
                  d.cnt = page_hit ? PAGE_WAIT : RD_WAIT;
               end
            end
         end
         afc_pkg::AFC_ST_READ: begin
            if (q.cnt == '0) begin
               d.rd_data = q.s2;
               d.rd_valid = 1'b1;
               d.cs_low = 1'b0;
               d.oe_low = 1'b0;
               d.gap = FLOAT_GAP;
               d.page_open = 1'b1;
               d.page_addr = q.addr;
               d.state = afc_pkg::AFC_ST_IDLE;
            end else begin
               d.cnt = q.cnt - CW'(1);
            end
         end
         afc_pkg::AFC_ST_WRITE: begin
            d.cnt = q.cnt + CW'(1);
            if (q.cnt == WR_PULSE - CW'(1)) begin
               d.we_low = 1'b0;
            end
            if (q.cnt == WR_CYCLE - CW'(1)) begin
               d.cs_low = 1'b0;
               d.we_low = 1'b0;
               d.dq_oe = 1'b0;
               d.wr_done = 1'b1;
               d.rd_gap = WR_TO_READ;
               // Select stays high at least one cycle even with zero phase
               d.gap = (q.last && flash_like) ? WR_RECOVER : WR_PHASE;
               d.state = afc_pkg::AFC_ST_IDLE;
            end
         end
         default: begin
            d.state = afc_pkg::AFC_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Forwarded flash clock runs from a divide-by-two, held low while in reset
   assign o_user_clock_out_port = q.clk_div;
   assign o_user_clock_float_port = 1'b0;

   // Primitive-path pins, floated as a group on request
   assign o_flash_select_out_port_n = ~q.cs_low;
   assign o_flash_select_float_port = i_cfg_pins_float;
   assign o_cfg_dq_out = q.dq_out[afc_pkg::CFG_DQ_W-1:0];
   assign o_pin_float_port = {afc_pkg::CFG_DQ_W{i_cfg_pins_float || ~q.dq_oe}};

   // Bypass pins from the alignment stage
   assign o_dq_hi_out = q.al_dq_hi;
   assign o_dq_hi_oe = q.al_dq_oe;
   assign o_mem_addr = q.al_addr;
   assign o_mem_output_low = q.al_oe_low;
   assign o_mem_write_low = q.al_we_low;

   assign o_rd_valid = q.rd_valid;
   assign o_rd_data = q.rd_data;
   assign o_wr_done = q.wr_done;
   assign o_busy = (q.state != afc_pkg::AFC_ST_IDLE) || (q.gap != '0);

endmodule : afc_async_flash_ctrl

/* File: hw/afc_pkg.sv */
package afc_pkg;

   // Bus clock period used to calibrate every timing counter
   localparam int unsigned BUS_CLOCK_PERIOD_PARAM = 10000;

   // Memory timing figures in picoseconds
   localparam int unsigned SELECT_TO_VALID_PARAM = 15000;
   localparam int unsigned ADDR_TO_VALID_PARAM = 15000;
   localparam int unsigned PAGE_ACCESS_PARAM = 25000;
   localparam int unsigned SELECT_HIGH_FLOAT_PARAM = 7000;
   localparam int unsigned OUTPUT_HIGH_FLOAT_PARAM = 7000;
   localparam int unsigned WRITE_CYCLE_PARAM = 15000;
   localparam int unsigned WRITE_PULSE_PARAM = 12000;
   localparam int unsigned WRITE_PHASE_PARAM = 12000;
   localparam int unsigned WRITE_HIGH_DRIVE_PARAM = 0;
   localparam int unsigned WRITE_RECOVERY_PARAM = 27000;

   // Whole cycles, rounded up so no interval is ever shorter than asked
   function automatic int unsigned ps_to_cycles(input int unsigned ps);
      return (ps + BUS_CLOCK_PERIOD_PARAM - 1) / BUS_CLOCK_PERIOD_PARAM;
   endfunction : ps_to_cycles

   function automatic int unsigned max2(input int unsigned a, input int unsigned b);
      return (a > b) ? a : b;
   endfunction : max2

   localparam int unsigned SELECT_TO_VALID_CYC = ps_to_cycles(SELECT_TO_VALID_PARAM);
   localparam int unsigned ADDR_TO_VALID_CYC = ps_to_cycles(ADDR_TO_VALID_PARAM);
   localparam int unsigned PAGE_ACCESS_CYC = ps_to_cycles(PAGE_ACCESS_PARAM);
   localparam int unsigned SELECT_HIGH_FLOAT_CYC = ps_to_cycles(SELECT_HIGH_FLOAT_PARAM);
   localparam int unsigned OUTPUT_HIGH_FLOAT_CYC = ps_to_cycles(OUTPUT_HIGH_FLOAT_PARAM);
   localparam int unsigned WRITE_CYCLE_CYC = ps_to_cycles(WRITE_CYCLE_PARAM);
   localparam int unsigned WRITE_PULSE_CYC = max2(ps_to_cycles(WRITE_PULSE_PARAM), 1);
   localparam int unsigned WRITE_PHASE_CYC = ps_to_cycles(WRITE_PHASE_PARAM);
   localparam int unsigned WRITE_HIGH_DRIVE_CYC = ps_to_cycles(WRITE_HIGH_DRIVE_PARAM);
   localparam int unsigned WRITE_RECOVERY_CYC = ps_to_cycles(WRITE_RECOVERY_PARAM);

   // Pipeline depths seen by the read path
   localparam int unsigned SYNC_STAGES = 2;
   localparam int unsigned ALIGN_STAGES = 1;

   // Bus geometry
   localparam int unsigned ADDR_W = 26;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned CFG_DQ_W = 4;
   localparam int unsigned PAGE_BITS = 4;
   localparam int unsigned CNT_W = 8;

   typedef enum logic [1:0] {
      AFC_MEM_SRAM,
      AFC_MEM_FLASH,
      AFC_MEM_PAGE_FLASH,
      AFC_MEM_PSRAM
   } afc_mem_type_t;

   typedef enum logic [1:0] {
      AFC_ST_IDLE,
      AFC_ST_READ,
      AFC_ST_WRITE
   } afc_state_t;

endpackage : afc_pkg

/* File: verif/afc_checker_asserts.sv */
`timescale 1ns/1ps
module afc_checker (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_cfg_pins_float,
   input wire logic o_cmd_ready,
   input wire logic o_rd_valid,
   input wire logic o_wr_done,
   input wire logic o_busy,
   input wire logic o_user_clock_out_port,
   input wire logic o_user_clock_float_port,
   input wire logic o_flash_select_out_port_n,
   input wire logic o_flash_select_float_port,
   input wire logic [afc_pkg::CFG_DQ_W-1:0] o_pin_float_port,
   input wire logic o_mem_write_low
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   chk_clk_driven: assert property (o_user_clock_float_port == 1'b0) else $error("clock pin floated");
   chk_clk_toggles: assert property (!$past(i_rst) && !$past(i_rst, 2) |->
      o_user_clock_out_port != $past(o_user_clock_out_port)) else $error("clock stalled");
   chk_sel_float: assert property (o_flash_select_float_port == i_cfg_pins_float) else $error("select float");
   chk_dq_float: assert property (i_cfg_pins_float && $past(i_cfg_pins_float) |->
      &o_pin_float_port) else $error("data pins driven");
   chk_pulse_width: assert property ($rose(o_mem_write_low) |=> o_mem_write_low) else $error("short strobe");
   chk_select_hold: assert property ($fell(o_flash_select_out_port_n) |=>
      !o_flash_select_out_port_n) else $error("short select");
   chk_select_gap: assert property ($rose(o_flash_select_out_port_n) |=>
      o_flash_select_out_port_n) else $error("short select gap");
   chk_read_wait: assert property ($rose(o_rd_valid) |-> !$past(o_flash_select_out_port_n) &&
      !$past(o_flash_select_out_port_n, 2) && !$past(o_flash_select_out_port_n, 3)) else $error("early capture");
   chk_read_float: assert property (o_rd_valid |=> !o_cmd_ready) else $error("no float gap");
   chk_write_gap: assert property (o_wr_done |=> o_busy) else $error("no write gap");
endmodule : afc_checker
bind afc_async_flash_ctrl afc_checker u_chk (.*);

/* File: verif/afc_flash_model.sv */
`timescale 1ns/1ps
module afc_flash_model (
   input wire logic i_clk,
   input wire logic i_sel_n,
   input wire logic i_oe,
   input wire logic i_we,
   input wire logic [afc_pkg::ADDR_W-1:0] i_addr,
   input wire logic [3:0] i_lo_out,
   input wire logic [3:0] i_lo_float,
   input wire logic [11:0] i_hi_out,
   input wire logic i_hi_oe,
   output logic [3:0] o_lo_in,
   output logic [11:0] o_hi_in
);
   logic [15:0] mem [16];
   logic [15:0] noise = 16'h5a3c;
   logic [15:0] rd;
   // Stored word only while a selected read is open, else a changing pattern
   assign rd = (!i_sel_n && i_oe) ? mem[i_addr[3:0]] : noise;
   assign o_lo_in = (~i_lo_float & i_lo_out) | (i_lo_float & rd[3:0]);
   assign o_hi_in = i_hi_oe ? i_hi_out : rd[15:4];
   always @(posedge i_clk) begin
      noise <= {noise[14:0], ~noise[15]};
      if (!i_sel_n && i_we) begin
         mem[i_addr[3:0]] <= {o_hi_in, o_lo_in};
      end
   end
endmodule : afc_flash_model

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   afc_pkg::afc_mem_type_t i_mem_type = afc_pkg::AFC_MEM_SRAM;
   logic i_cfg_pins_float = 1'b0, i_cmd_valid = 1'b0, i_cmd_write = 1'b0, i_cmd_last = 1'b0;
   logic [25:0] i_cmd_addr = 26'h0;
   logic [15:0] i_cmd_wdata = 16'h0;
   logic o_cmd_ready, o_rd_valid, o_wr_done, o_busy, o_user_clock_out_port, o_user_clock_float_port;
   logic o_flash_select_out_port_n, o_flash_select_float_port, o_dq_hi_oe, o_mem_output_low, o_mem_write_low;
   logic [3:0] o_cfg_dq_out, o_pin_float_port, i_pin_sense_port;
   logic [11:0] o_dq_hi_out, i_dq_hi_in;
   logic [25:0] o_mem_addr;
   logic [15:0] o_rd_data;
   logic [15:0] exp_mem [16];
   logic [31:0] rnd = 32'h87d22691;
   int n_errors = 0, checks_done = 0, lat, gap, g0, l0;
   always #50 i_clk = ~i_clk;
   afc_async_flash_ctrl dut (.*);
   afc_flash_model mdl (.i_clk(i_clk), .i_sel_n(o_flash_select_out_port_n), .i_oe(o_mem_output_low),
      .i_we(o_mem_write_low), .i_addr(o_mem_addr), .i_lo_out(o_cfg_dq_out), .i_lo_float(o_pin_float_port),
      .i_hi_out(o_dq_hi_out), .i_hi_oe(o_dq_hi_oe), .o_lo_in(i_pin_sense_port), .o_hi_in(i_dq_hi_in));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
      end
   endtask : check_data
   task automatic check_cycles(input int got, input int exp);
      checks_done++;
      if (got != exp) begin
         n_errors++;
         $display("unexpected at %0t: %0d cycles, wanted %0d", $time, got, exp);
      end
   endtask : check_cycles
   task automatic results();
      $display("errors %0d, checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : results
   // One request, held until taken; lat runs to the answer, gap to ready again
   task automatic op(input logic wr, input logic last, input logic [25:0] a, input logic [15:0] d,
      input afc_pkg::afc_mem_type_t t);
      int n;
      @(posedge i_clk);
      i_mem_type <= t;
      i_cmd_valid <= 1'b1;
      i_cmd_write <= wr;
      i_cmd_last <= last;
      i_cmd_addr <= a;
      i_cmd_wdata <= d;
      @(negedge i_clk);
      for (n = 0; n < 40 && o_cmd_ready !== 1'b1; n++) @(negedge i_clk);
      @(posedge i_clk);
      i_cmd_valid <= 1'b0;
      @(negedge i_clk);
      for (lat = 1; lat < 40 && o_rd_valid !== 1'b1 && o_wr_done !== 1'b1; lat++) @(negedge i_clk);
      for (gap = 0; gap < 40 && o_cmd_ready !== 1'b1; gap++) @(negedge i_clk);
   endtask : op
   initial begin
      #(100 * 20000);
      n_errors++;
      $display("unexpected at %0t: watchdog expired before the tests ended", $time);
      results();
   end
   initial begin
      repeat (20) @(posedge i_clk);
      i_rst <= 1'b0;
      @(negedge i_clk);
      check_data({o_cmd_ready, o_flash_select_out_port_n, o_wr_done, o_rd_valid, o_pin_float_port,
         o_user_clock_float_port, o_busy}, 32'h33c);
      @(posedge i_clk);
      i_cfg_pins_float <= 1'b1;
      repeat (3) @(negedge i_clk);
      check_data({o_flash_select_float_port, o_pin_float_port}, 32'h1f);
      @(posedge i_clk);
      i_cfg_pins_float <= 1'b0;
      for (int i = 0; i < 16; i++) begin
         rnd = lfsr(rnd);
         op(1'b1, i[2], {rnd[31:10], i[3:0]}, rnd[15:0], afc_pkg::afc_mem_type_t'(i[1:0]));
         exp_mem[i] = rnd[15:0];
         if (i == 0) g0 = gap;
         check_cycles(gap, g0 + ((i[2] && i[1:0] != 0) ? int'(afc_pkg::WRITE_RECOVERY_CYC)
            - int'(afc_pkg::WRITE_PHASE_CYC) : 0));
      end
      for (int i = 0; i < 16; i++) begin
         rnd = lfsr(rnd);
         op(1'b0, 1'b0, {rnd[31:10], i[3:0]}, rnd[15:0], afc_pkg::AFC_MEM_FLASH);
         check_data(o_rd_data, exp_mem[i]);
      end
      for (int t = 1; t < 3; t++) begin
         op(1'b0, 1'b0, 26'(t * 16 + 3), 16'h0, afc_pkg::afc_mem_type_t'(t));
         l0 = lat;
         op(1'b0, 1'b0, 26'(t * 16 + 4), 16'h0, afc_pkg::afc_mem_type_t'(t));
         check_data(o_rd_data, exp_mem[4]);
         check_cycles(lat - l0, (t == 2) ? int'(afc_pkg::PAGE_ACCESS_CYC)
            - int'(afc_pkg::ADDR_TO_VALID_CYC) : 0);
      end
      results();
   end
endmodule : tb_top
